// *** verilog/ccm_core_regs.vh ***
// constants for the 12-bit-instruction execution core: status bits, opcodes,
// data-memory map, reset values and program-space masks.
// assumes inclusion by bare name from the core and alu files.
`ifndef CCM_CORE_REGS_VH
`define CCM_CORE_REGS_VH

// ==================================================================
// program space
`define CCM_PC_W 11
`define CCM_PC_MASK_SMALL 11'h1ff
`define CCM_PC_MASK_LARGE 11'h3ff
`define CCM_RESET_VECTOR 11'h000
`define CCM_PAGE_BIT 5
`define CCM_NOP_WORD 12'h000

// ==================================================================
// data memory map, 5-bit direct addresses
`define CCM_A_INDIRECT 5'h00
`define CCM_A_TIMER 5'h01
`define CCM_A_CNT_LOW 5'h02
`define CCM_A_STATUS 5'h03
`define CCM_A_POINTER 5'h04
`define CCM_A_CALIB 5'h05
`define CCM_A_GPIO 5'h06
`define CCM_A_GPR_LO 5'h07
`define CCM_A_BANKED 5'h10
`define CCM_GPR_SHARED 9
`define CCM_GPR_DEPTH 41
`define CCM_BANK_BIT 5
`define CCM_PTR_FILL_SMALL 8'he0
`define CCM_PTR_FILL_LARGE 8'hc0

// ==================================================================
// status bit positions
`define CCM_ST_WAKE 7
`define CCM_ST_TIMEOUT 4
`define CCM_ST_POWER 3
`define CCM_ST_ZERO 2
`define CCM_ST_NIBBLE 1
`define CCM_ST_CARRY 0

// ==================================================================
// reset values
`define CCM_RST_STATUS 8'h18
`define CCM_RST_POINTER 8'he0
`define CCM_RST_CALIB 8'h80
`define CCM_RST_OPTION 8'hff
`define CCM_RST_DIR 6'h3f
`define CCM_RST_BYTE 8'h00

// ==================================================================
// alu operations
`define CCM_OP_PASS 4'h0
`define CCM_OP_ADD 4'h1
`define CCM_OP_SUB 4'h2
`define CCM_OP_AND 4'h3
`define CCM_OP_IOR 4'h4
`define CCM_OP_XOR 4'h5
`define CCM_OP_COM 4'h6
`define CCM_OP_INC 4'h7
`define CCM_OP_DEC 4'h8
`define CCM_OP_RR 4'h9
`define CCM_OP_RL 4'ha
`define CCM_OP_SWAP 4'hb
`define CCM_OP_CLR 4'hc
`define CCM_OP_BCLR 4'hd
`define CCM_OP_BSET 4'he

// ==================================================================
// misc instruction words (bits 4:0 with bit 5 clear, group 0)
`define CCM_MISC_OPTION 5'h02
`define CCM_MISC_DIR 5'h06

`endif

// *** verilog/ccm_alu.v ***
// 8-bit two's complement alu with carry and nibble carry outputs.
// assumes the caller decides which flags to keep for each operation.
`timescale 1ns/1ps
`include "ccm_core_regs.vh"

module ccm_alu (
  input wire [7:0] opnd_in,  // file register or literal
  input wire [7:0] w_in,     // operand latch
  input wire [3:0] op_in,    // operation code
  input wire carry_in,       // current carry flag, used by rotates
  input wire [2:0] bit_in,   // bit index for set/clear
  output reg [7:0] res_out,  // result
  output reg carry_out,      // carry, or not-borrow on subtract
  output reg dcarry_out,     // nibble carry, or not-borrow on subtract
  output wire zero_out       // result is zero
);

  reg [8:0] sum9;
  reg [4:0] lo5;
  reg [7:0] onehot;

  // ==================================================================
  // combinational datapath
  always @* begin
    sum9 = 9'h000;
    lo5 = 5'h00;
    onehot = 8'h01 << bit_in;
    res_out = opnd_in;
    carry_out = carry_in;
    dcarry_out = 1'b0;
    case (op_in)
      `CCM_OP_ADD: begin
        sum9 = {1'b0, opnd_in} + {1'b0, w_in};
        lo5 = {1'b0, opnd_in[3:0]} + {1'b0, w_in[3:0]};
        res_out = sum9[7:0];
        carry_out = sum9[8];
        dcarry_out = lo5[4];
      end
      // subtract as f + ~w + 1: outputs are inverted borrows
      `CCM_OP_SUB: begin
        sum9 = {1'b0, opnd_in} + {1'b0, ~w_in} + 9'h001;
        lo5 = {1'b0, opnd_in[3:0]} + {1'b0, ~w_in[3:0]} + 5'h01;
        res_out = sum9[7:0];
        carry_out = sum9[8];
        dcarry_out = lo5[4];
      end
      `CCM_OP_AND: res_out = opnd_in & w_in;
      `CCM_OP_IOR: res_out = opnd_in | w_in;
      `CCM_OP_XOR: res_out = opnd_in ^ w_in;
      `CCM_OP_COM: res_out = ~opnd_in;
      `CCM_OP_INC: res_out = opnd_in + 8'h01;
      `CCM_OP_DEC: res_out = opnd_in - 8'h01;
      // rotates pass through carry, nine bits in the ring
      `CCM_OP_RR: begin
        res_out = {carry_in, opnd_in[7:1]};
        carry_out = opnd_in[0];
      end
      `CCM_OP_RL: begin
        res_out = {opnd_in[6:0], carry_in};
        carry_out = opnd_in[7];
      end
      `CCM_OP_SWAP: res_out = {opnd_in[3:0], opnd_in[7:4]};
      `CCM_OP_CLR: res_out = 8'h00;
      `CCM_OP_BCLR: res_out = opnd_in & ~onehot;
      `CCM_OP_BSET: res_out = opnd_in | onehot;
      default: res_out = opnd_in;
    endcase
  end

  assign zero_out = (res_out == 8'h00);

endmodule // ccm_alu

// *** verilog/ccm_core.v ***
// execution core: four-phase sequencer, fetch/execute pipeline, program
// counter with paging and wrap, data register file with banking.
// assumes asynchronous-read program memory on pmem_addr_out/pmem_data_in.
`timescale 1ns/1ps
`include "ccm_core_regs.vh"

// Notes on behaviour
// - clock divided into four one-hot phases
// - counter advances phase one, word captured four
// - fetch overlaps execute, one instruction per cycle
// - counter-changing instructions take two cycles
// - operand read phase two, result written four
// - 8-bit alu: add, subtract, shift, logic
// - operands: latch with file register or literal
// - operand latch has no data address
// - alu updates carry, nibble and zero flags
// - subtract flags mean inverted borrows
// - 12-bit instruction bus, separate from data
// - counter wraps within implemented program size
// - execution starts at address zero
// - one status bit selects program page
// - small file: 7 special, 25 general
// - large file adds 16 banked general registers
// - all specials mapped, direct or indirect reachable
// - status destination: flag bits follow alu
// - jump: word gives 8:0, page bit 9
// - call or low-byte write: bit 8 zero
module ccm_core #(
  parameter LARGE_MAP = 1  // 1: 1K program and banked file, 0: 512 words
) (
  input wire clk_in,                        // 50 MHz core clock
  input wire nrst_in,                       // async reset, active low
  output reg [`CCM_PC_W-1:0] pmem_addr_out, // program memory address
  input wire [11:0] pmem_data_in,           // program word
  input wire [5:0] gpio_in,                 // port pin levels
  output reg [5:0] gpio_out,                // port output latch
  output reg [5:0] gpio_oe_out,             // port drive enables, high drives
  output reg [7:0] option_out,              // option register contents
  output reg [3:0] phase_out,               // one-hot phase, bit0 phase one
  output reg [7:0] acc_out,                 // operand latch copy
  output reg [7:0] status_out               // status register copy
);

  // ==================================================================
  // state and declarations
  localparam PH1 = 4'b0001;
  localparam PH2 = 4'b0010;
  localparam PH3 = 4'b0100;
  localparam PH4 = 4'b1000;
  localparam [`CCM_PC_W-1:0] PC_MASK =
    (LARGE_MAP != 0) ? `CCM_PC_MASK_LARGE : `CCM_PC_MASK_SMALL;
  localparam [7:0] PTR_FILL =
    (LARGE_MAP != 0) ? `CCM_PTR_FILL_LARGE : `CCM_PTR_FILL_SMALL;

  reg [`CCM_PC_W-1:0] pc_r;
  reg [11:0] ir_r;
  reg [7:0] w_r;
  reg [7:0] opnd_r;
  reg [7:0] timer_r;
  reg [7:0] status_r;
  reg [7:0] ptr_r;
  reg [7:0] calib_r;
  reg [`CCM_PC_W-1:0] stk0_r;
  reg [`CCM_PC_W-1:0] stk1_r;
  reg [7:0] gpr_r [0:`CCM_GPR_DEPTH-1];
  reg [5:0] pin_s1_r;
  reg [5:0] pin_s2_r;
  reg [5:0] pin_s3_r;
  reg [5:0] pin_r;
  integer i;
  integer j;
  reg [7:0] status_next;

  // ==================================================================
  // register file index: shared block, bank 0 window, bank 1 window
  function [5:0] gpr_index;
    input bank;
    input [4:0] a;
    begin
      if (a < `CCM_A_BANKED)
        gpr_index = {1'b0, a - `CCM_A_GPR_LO};
      else if (bank && (LARGE_MAP != 0))
        gpr_index = {1'b0, a} - 6'h10 + 6'd`CCM_GPR_SHARED + 6'h10;
      else
        gpr_index = {1'b0, a} - 6'h10 + 6'd`CCM_GPR_SHARED;
    end
  endfunction

  // ==================================================================
  // effective address: indirect through pointer, bank from pointer
  wire ind_sel = (ir_r[4:0] == `CCM_A_INDIRECT);
  wire [4:0] ea = ind_sel ? ptr_r[4:0] : ir_r[4:0];
  wire ea_bank = ptr_r[`CCM_BANK_BIT] & (LARGE_MAP != 0);
  wire [5:0] ea_idx = gpr_index(ea_bank, ea);

  // data read mux; the operand latch has no address here
  reg [7:0] rd_data;
  always @* begin
    if (ea == `CCM_A_INDIRECT)
      rd_data = 8'h00;
    else if (ea == `CCM_A_TIMER)
      rd_data = timer_r;
    else if (ea == `CCM_A_CNT_LOW)
      rd_data = pmem_addr_out[7:0];
    else if (ea == `CCM_A_STATUS)
      rd_data = status_r;
    else if (ea == `CCM_A_POINTER)
      rd_data = ptr_r | PTR_FILL;
    else if (ea == `CCM_A_CALIB)
      rd_data = calib_r;
    else if (ea == `CCM_A_GPIO)
      rd_data = {2'b00, pin_r};
    else
      rd_data = gpr_r[ea_idx];
  end

  // ==================================================================
  // instruction decode from the captured word
  reg [3:0] alu_op;
  reg use_lit, wr_f, wr_w, aff_z, aff_cdc, aff_c;
  reg do_jump, do_call, do_ret, skip_z, skip_clr, skip_set, do_option, do_dir;

  always @* begin
    alu_op = `CCM_OP_PASS;
    use_lit = 1'b0;
    wr_f = 1'b0;
    wr_w = 1'b0;
    aff_z = 1'b0;
    aff_cdc = 1'b0;
    aff_c = 1'b0;
    do_jump = 1'b0;
    do_call = 1'b0;
    do_ret = 1'b0;
    skip_z = 1'b0;
    skip_clr = 1'b0;
    skip_set = 1'b0;
    do_option = 1'b0;
    do_dir = 1'b0;
    if (ir_r[11:10] == 2'b00) begin
      // byte-oriented file operations, bit 5 selects file destination
      wr_f = ir_r[5];
      wr_w = ~ir_r[5];
      case (ir_r[9:6])
        4'h0: begin
          wr_w = 1'b0;
          if (!ir_r[5]) begin
            do_option = (ir_r[4:0] == `CCM_MISC_OPTION);
            do_dir = (ir_r[4:0] == `CCM_MISC_DIR);
          end else begin
            alu_op = `CCM_OP_PASS;
            use_lit = 1'b1;
          end
        end
        4'h1: begin alu_op = `CCM_OP_CLR; aff_z = 1'b1; end
        4'h2: begin alu_op = `CCM_OP_SUB; aff_z = 1'b1; aff_cdc = 1'b1; end
        4'h3: begin alu_op = `CCM_OP_DEC; aff_z = 1'b1; end
        4'h4: begin alu_op = `CCM_OP_IOR; aff_z = 1'b1; end
        4'h5: begin alu_op = `CCM_OP_AND; aff_z = 1'b1; end
        4'h6: begin alu_op = `CCM_OP_XOR; aff_z = 1'b1; end
        4'h7: begin alu_op = `CCM_OP_ADD; aff_z = 1'b1; aff_cdc = 1'b1; end
        4'h8: begin alu_op = `CCM_OP_PASS; aff_z = 1'b1; end
        4'h9: begin alu_op = `CCM_OP_COM; aff_z = 1'b1; end
        4'ha: begin alu_op = `CCM_OP_INC; aff_z = 1'b1; end
        4'hb: begin alu_op = `CCM_OP_DEC; skip_z = 1'b1; end
        4'hc: begin alu_op = `CCM_OP_RR; aff_c = 1'b1; end
        4'hd: begin alu_op = `CCM_OP_RL; aff_c = 1'b1; end
        4'he: alu_op = `CCM_OP_SWAP;
        default: begin alu_op = `CCM_OP_INC; skip_z = 1'b1; end
      endcase
    end else if (ir_r[11:10] == 2'b01) begin
      // bit operations and bit tests
      case (ir_r[9:8])
        2'b00: begin alu_op = `CCM_OP_BCLR; wr_f = 1'b1; end
        2'b01: begin alu_op = `CCM_OP_BSET; wr_f = 1'b1; end
        2'b10: skip_clr = 1'b1;
        default: skip_set = 1'b1;
      endcase
    end else begin
      // literal and branch group
      use_lit = 1'b1;
      case (ir_r[10:8])
        3'b000: begin do_ret = 1'b1; wr_w = 1'b1; end
        3'b001: do_call = 1'b1;
        3'b010: do_jump = 1'b1;
        3'b011: do_jump = 1'b1;
        3'b100: wr_w = 1'b1;
        3'b101: begin alu_op = `CCM_OP_IOR; wr_w = 1'b1; aff_z = 1'b1; end
        3'b110: begin alu_op = `CCM_OP_AND; wr_w = 1'b1; aff_z = 1'b1; end
        default: begin alu_op = `CCM_OP_XOR; wr_w = 1'b1; aff_z = 1'b1; end
      endcase
    end
  end

  // ==================================================================
  // alu: latch against file operand or literal
  wire [7:0] alu_a = (use_lit && !(ir_r[11:10] == 2'b00)) ? ir_r[7:0] :
                     (use_lit ? w_r : opnd_r);
  wire [7:0] alu_res;
  wire alu_c;
  wire alu_dc;
  wire alu_z;

  ccm_alu u_alu (
    .opnd_in(alu_a),
    .w_in(w_r),
    .op_in(alu_op),
    .carry_in(status_r[`CCM_ST_CARRY]),
    .bit_in(ir_r[7:5]),
    .res_out(alu_res),
    .carry_out(alu_c),
    .dcarry_out(alu_dc),
    .zero_out(alu_z)
  );

  // ==================================================================
  // branch and flush decisions, valid during phase four
  wire tst_bit = opnd_r[ir_r[7:5]];
  wire pcl_wr = wr_f && (ea == `CCM_A_CNT_LOW);
  wire skip = (skip_z && alu_z) || (skip_clr && !tst_bit) || (skip_set && tst_bit);
  wire page = status_r[`CCM_PAGE_BIT];
  // jump: word gives 8:0, page bit gives 9
  wire [`CCM_PC_W-1:0] jump_tgt = {1'b0, page, ir_r[8:0]} & PC_MASK;
  // call or low-byte write: bit 8 forced clear
  wire [`CCM_PC_W-1:0] call_tgt = {1'b0, page, 1'b0, (do_call ? ir_r[7:0] : alu_res)}
                                  & PC_MASK;
  wire redirect = do_jump || do_call || do_ret || pcl_wr;
  wire flush = redirect || skip;

  // ==================================================================
  // phase sequencer, four one-hot quarters per cycle
  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      phase_out <= PH1;
    end else begin
      // the output flop is the state itself, so no copy can drift from it
      case (phase_out)
        PH1: phase_out <= PH2;
        PH2: phase_out <= PH3;
        PH3: phase_out <= PH4;
        default: phase_out <= PH1;
      endcase
    end
  end

  // ==================================================================
  // fetch path: counter steps in phase one, word taken in phase four
  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pc_r <= `CCM_RESET_VECTOR;
      pmem_addr_out <= `CCM_RESET_VECTOR;
      ir_r <= `CCM_NOP_WORD;
      stk0_r <= `CCM_RESET_VECTOR;
      stk1_r <= `CCM_RESET_VECTOR;
    end else if (phase_out == PH1) begin
      pmem_addr_out <= pc_r;
      pc_r <= (pc_r + 1'b1) & PC_MASK;
    end else if (phase_out == PH4) begin
      // 12-bit word arrives whole on its own bus
      ir_r <= flush ? `CCM_NOP_WORD : pmem_data_in;
      if (do_call) begin
        stk1_r <= stk0_r;
        stk0_r <= pmem_addr_out;
      end else if (do_ret) begin
        stk0_r <= stk1_r;
      end
      if (do_jump)
        pc_r <= jump_tgt;
      else if (do_call || pcl_wr)
        pc_r <= call_tgt;
      else if (do_ret)
        pc_r <= stk0_r & PC_MASK;
    end
  end

  // ==================================================================
  // pin synchroniser: a change counts once stages two and three agree
  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pin_s1_r <= 6'h00;
      pin_s2_r <= 6'h00;
      pin_s3_r <= 6'h00;
      pin_r <= 6'h00;
    end else begin
      pin_s1_r <= gpio_in;
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
      for (i = 0; i < 6; i = i + 1)
        if (pin_s2_r[i] == pin_s3_r[i])
          pin_r[i] <= pin_s3_r[i];
    end
  end

  // ==================================================================
  // execute: operand in phase two, results and flags in phase four
  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      opnd_r <= `CCM_RST_BYTE;
      w_r <= `CCM_RST_BYTE;
      acc_out <= `CCM_RST_BYTE;
      timer_r <= `CCM_RST_BYTE;
      status_r <= `CCM_RST_STATUS;
      status_out <= `CCM_RST_STATUS;
      ptr_r <= `CCM_RST_POINTER;
      calib_r <= `CCM_RST_CALIB;
      option_out <= `CCM_RST_OPTION;
      gpio_oe_out <= ~`CCM_RST_DIR; // all pins start as inputs
      gpio_out <= 6'h00;
      for (j = 0; j < `CCM_GPR_DEPTH; j = j + 1)
        gpr_r[j] <= `CCM_RST_BYTE;
    end else if (phase_out == PH2) begin
      opnd_r <= rd_data;
    end else if (phase_out == PH4) begin
      if (wr_w) begin
        w_r <= alu_res;
        acc_out <= alu_res;
      end
      if (do_option)
        option_out <= w_r;
      // a set direction bit means input, so the enable is its inverse
      if (do_dir)
        gpio_oe_out <= ~w_r[5:0];
      // destination write into the mapped file
      if (wr_f) begin
        if (ea == `CCM_A_TIMER)
          timer_r <= alu_res;
        else if (ea == `CCM_A_POINTER)
          ptr_r <= alu_res;
        else if (ea == `CCM_A_CALIB)
          calib_r <= alu_res;
        else if (ea == `CCM_A_GPIO)
          gpio_out <= alu_res[5:0];
        else if (ea >= `CCM_A_GPR_LO)
          gpr_r[ea_idx] <= alu_res;
      end
      // status: plain bits from a write, flag bits from the alu
      status_r <= status_next;
      status_out <= status_next;
    end
  end

  // status next value; timeout and power bits are read-only
  always @* begin
    status_next = status_r;
    if (wr_f && (ea == `CCM_A_STATUS)) begin
      status_next[`CCM_ST_WAKE] = alu_res[`CCM_ST_WAKE];
      status_next[`CCM_PAGE_BIT] = alu_res[`CCM_PAGE_BIT];
      // any flag-updating instruction loses its write to all three flags
      if (!(aff_z || aff_cdc || aff_c)) begin
        status_next[`CCM_ST_ZERO] = alu_res[`CCM_ST_ZERO];
        status_next[`CCM_ST_NIBBLE] = alu_res[`CCM_ST_NIBBLE];
        status_next[`CCM_ST_CARRY] = alu_res[`CCM_ST_CARRY];
      end
    end
    if (aff_z)
      status_next[`CCM_ST_ZERO] = alu_z;
    if (aff_cdc) begin
      status_next[`CCM_ST_NIBBLE] = alu_dc;
      status_next[`CCM_ST_CARRY] = alu_c;
    end
    if (aff_c)
      status_next[`CCM_ST_CARRY] = alu_c;
  end

endmodule // ccm_core

// *** test/ccm_prog_mem.sv ***
// program memory model: asynchronous-read rom on the core's fetch bus.
// assumes the bench refills it through wipe and mem while the core is in reset.
`timescale 1ns/1ps

module ccm_prog_mem #(
  parameter logic [7:0] CAL = 8'h5a  // calibration literal, arbitrary
) (
  input wire [10:0] addr_in,  // fetch address
  output wire [11:0] data_out // program word
);
  logic [11:0] mem [0:1023];

  // ==========
  // fetch path: whole 12-bit word, no wait states
  assign data_out = mem[addr_in[9:0]];

  // refill with nops; the core has no write path, so the last word keeps
  // its calibration literal for the whole run
  task automatic wipe();
    for (int i = 0; i < 1023; i++) begin
      mem[i] = 12'h000;
    end
    mem[1023] = {4'hc, CAL};
  endtask
endmodule // ccm_prog_mem

// *** test/ccm_core_sva.sv ***
// port assertions for the core: phases, fetch timing, reset state, paging.
// assumes a single clock domain; bound to every core instance below.
`timescale 1ns/1ps
`include "ccm_core_regs.vh"

module ccm_core_sva #(
  parameter LARGE_MAP = 1  // program size select, as in the core
) (
  input wire clk_in,              // clock
  input wire nrst_in,             // reset, low
  input wire [10:0] pmem_addr_out, // fetch address
  input wire [5:0] gpio_out,      // port latch
  input wire [5:0] gpio_oe_out,   // drive enables
  input wire [7:0] option_out,    // option
  input wire [3:0] phase_out,     // phases
  input wire [7:0] acc_out,       // operand latch
  input wire [7:0] status_out     // status
);
  localparam logic [10:0] TOP = LARGE_MAP ? `CCM_PC_MASK_LARGE : `CCM_PC_MASK_SMALL;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);

  // ==========
  // sequencer and fetch
  // past guard: the first edge after release still sees the reset phase
  property p_phase_step;
    $past(nrst_in) |-> $onehot(phase_out) && phase_out == {$past(phase_out[2:0]), $past(phase_out[3])};
  endproperty
  a_phase_step: assert property (p_phase_step) else $error("phase did not step");
  property p_addr_hold;
    phase_out != 4'b0010 |-> $stable(pmem_addr_out);
  endproperty
  a_addr_hold: assert property (p_addr_hold) else $error("address moved off phase one");
  property p_fetch_gap;
    $changed(pmem_addr_out) |=> $stable(pmem_addr_out)[*3];
  endproperty
  a_fetch_gap: assert property (p_fetch_gap) else $error("fetch closer than a cycle");
  property p_reset_vec;
    $rose(nrst_in) |-> pmem_addr_out == `CCM_RESET_VECTOR ##5 pmem_addr_out == 11'h001;
  endproperty
  a_reset_vec: assert property (p_reset_vec) else $error("start address wrong");
  property p_reset_vals;
    $rose(nrst_in) |-> phase_out == 4'b0001 && status_out == `CCM_RST_STATUS
      && option_out == `CCM_RST_OPTION && acc_out == 8'h00 && gpio_oe_out == 6'h00;
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("reset state wrong");
  property p_range;
    pmem_addr_out <= TOP;
  endproperty
  a_range: assert property (p_range) else $error("address past program size");

  // ==========
  // results land only at the phase-four edge
  property p_write_ph4;
    phase_out != 4'b0001 |-> $stable({acc_out, status_out, option_out, gpio_out, gpio_oe_out});
  endproperty
  a_write_ph4: assert property (p_write_ph4) else $error("result written off phase four");
  // page one is entered by the page bit or by counting across it
  property p_page;
    $rose(pmem_addr_out[9]) |-> $past(status_out[`CCM_PAGE_BIT]) || $past(pmem_addr_out) == 11'h1ff;
  endproperty
  a_page: assert property (p_page) else $error("page entered without page bit");

  c_page: cover property ($rose(pmem_addr_out[9]));
  c_option: cover property ($changed(option_out));
  c_zero: cover property ($rose(status_out[`CCM_ST_ZERO]));
endmodule // ccm_core_sva

bind ccm_core ccm_core_sva #(.LARGE_MAP(LARGE_MAP)) u_sva (.clk_in(clk_in), .nrst_in(nrst_in),
  .pmem_addr_out(pmem_addr_out), .gpio_out(gpio_out), .gpio_oe_out(gpio_oe_out),
  .option_out(option_out), .phase_out(phase_out), .acc_out(acc_out), .status_out(status_out));

// *** test/tb_top.sv ***
// self-checking bench: program table, then jump, call, wrap, port and reset cases.
// assumes the core, its header and the rom model are compiled before it.
`timescale 1ns/1ps

module tb_top;
  localparam logic [7:0] CAL = 8'h5a;  // arbitrary calibration literal
  typedef struct packed {
    logic [95:0] p;  // eight words, first at the top
    logic [7:0] w;   // expected operand latch
    logic [7:0] st;  // expected status
  } ccm_row_t;
  ccm_row_t rows [13];
  logic clk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic [5:0] gpio_in = 6'h2d;
  wire [10:0] pmem_addr_out;
  wire [11:0] pmem_data_in;
  wire [5:0] gpio_out;
  wire [5:0] gpio_oe_out;
  wire [7:0] option_out;
  wire [3:0] phase_out;
  wire [7:0] acc_out;
  wire [7:0] status_out;
  int n_fail = 0;
  int comparisons = 0;
  int cyc = 0;
  logic [1023:0] hit;
  logic [10:0] prev_a;
  logic wrapped;

  always #10 clk_in = ~clk_in;

  ccm_core #(.LARGE_MAP(1)) uut (.clk_in(clk_in), .nrst_in(nrst_in),
    .pmem_addr_out(pmem_addr_out), .pmem_data_in(pmem_data_in), .gpio_in(gpio_in),
    .gpio_out(gpio_out), .gpio_oe_out(gpio_oe_out), .option_out(option_out),
    .phase_out(phase_out), .acc_out(acc_out), .status_out(status_out));
  ccm_prog_mem #(.CAL(CAL)) u_mem (.addr_in(pmem_addr_out), .data_out(pmem_data_in));

  // ==========
  // fetch log at each word capture, plus the hang limit
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (phase_out == 4'b1000) begin
      hit[pmem_addr_out[9:0]] <= 1'b1;
      wrapped <= wrapped | (prev_a == 11'h3ff && pmem_addr_out == 11'h000);
      prev_a <= pmem_addr_out;
    end
    if (cyc == 5000) begin
      n_fail++;
      conclude();
    end
  end

  task automatic chk(input string nm, input logic [11:0] exp, input logic [11:0] got);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // reset, then refill the rom; the word after the program parks in a loop
  task automatic load(input logic [95:0] p);
    @(posedge clk_in);
    nrst_in <= 1'b0;
    @(posedge clk_in);
    u_mem.wipe();
    for (int i = 0; i < 8; i++) begin
      u_mem.mem[i] = p[95-12*i -: 12];
    end
    u_mem.mem[8] = 12'ha08;
    hit = '0;
    wrapped = 1'b0;
    prev_a = 11'h000;
  endtask

  task automatic go(input int n);
    @(posedge clk_in);
    nrst_in <= 1'b1;
    repeat (n) @(posedge clk_in);
    #1;
  endtask

  task automatic conclude();
    if (n_fail == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    rows = '{'{96'hc0f_028_c01_1c8_000_000_000_000, 8'h10, 8'h1a},
      '{96'hc80_028_c80_1c8_000_000_000_000, 8'h00, 8'h1d},
      '{96'hc01_028_c02_088_000_000_000_000, 8'hff, 8'h18},
      '{96'hc05_028_c05_088_000_000_000_000, 8'h00, 8'h1f},
      '{96'hcf0_e0f_000_000_000_000_000_000, 8'h00, 8'h1c},
      '{96'hc81_028_308_000_000_000_000_000, 8'h40, 8'h19},
      '{96'hc5a_fff_000_000_000_000_000_000, 8'ha5, 8'h18},
      '{96'hc81_028_308_063_000_000_000_000, 8'h40, 8'h1d},
      '{96'h206_000_000_000_000_000_000_000, 8'h2d, 8'h18},
      '{96'hc30_024_c5c_020_c00_210_000_000, 8'h5c, 8'h18},
      '{96'hc30_024_c5c_020_c10_024_210_000, 8'h00, 8'h1c},
      '{96'hc0f_028_388_000_000_000_000_000, 8'hf0, 8'h18},
      '{96'hc81_028_348_000_000_000_000_000, 8'h02, 8'h19}};
    // state while the first reset is held
    repeat (20) @(posedge clk_in);
    #1;
    chk("addr", 12'h000, 12'(pmem_addr_out));
    chk("phase", 12'h001, 12'(phase_out));
    chk("status", 12'h018, 12'(status_out));
    chk("option", 12'h0ff, 12'(option_out));
    // straight-line programs: alu, flags, status target, banked file
    foreach (rows[k]) begin
      load(rows[k].p);
      go(52);
      chk("acc", 12'(rows[k].w), 12'(acc_out));
      chk("status", 12'(rows[k].st), 12'(status_out));
    end
    // jump into page one; the prefetched word after it must not run
    load(96'h5a3_c33_a10_c77_000_000_000_000);
    u_mem.mem[12'h210] = 12'ha10;
    go(60);
    chk("acc", 12'h033, 12'(acc_out));
    chk("hit 210", 12'h001, {11'h000, hit[10'h210]});
    chk("hit 010", 12'h000, {11'h000, hit[10'h010]});
    chk("status", 12'h038, 12'(status_out));
    // call into page one: bit 8 of the target is forced low
    load(96'h5a3_920_4a3_a03_000_000_000_000);
    u_mem.mem[12'h220] = 12'h844;
    go(60);
    chk("acc", 12'h044, 12'(acc_out));
    chk("hit 220", 12'h001, {11'h000, hit[10'h220]});
    chk("hit 320", 12'h000, {11'h000, hit[10'h320]});
    // run off the last word: calibration literal, then wrap to zero
    load(96'h5a3_bff_000_000_000_000_000_000);
    go(60);
    chk("acc", 12'(CAL), 12'(acc_out));
    chk("wrap", 12'h001, {11'h000, wrapped});
    // option, direction and port latch writes
    load(96'hc0a_002_c15_006_c3f_026_000_000);
    go(52);
    chk("option", 12'h00a, 12'(option_out));
    chk("drive", 12'h02a, 12'(gpio_oe_out));
    chk("gpio", 12'h03f, 12'(gpio_out));
    // reset in mid-run restores the start state
    @(posedge clk_in);
    nrst_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    #1;
    chk("option", 12'h0ff, 12'(option_out));
    chk("drive", 12'h000, 12'(gpio_oe_out));
    chk("addr", 12'h000, 12'(pmem_addr_out));
    conclude();
  end
endmodule // tb_top
